// File: cxlt_defs.svh
`ifndef CXLT_DEFS_SVH
`define CXLT_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define CXLT_ADDR_W        4
`define CXLT_OFF_CTRL      4'h0
`define CXLT_OFF_STATUS    4'h4
`define CXLT_OFF_IRQ_STAT  4'h8
`define CXLT_OFF_IRQ_MASK  4'hC

// Control register layout.
`define CXLT_CTRL_W        12
`define CXLT_CTRL_RST      12'h000
`define CXLT_F_CODE        3:0
`define CXLT_F_FINE        4
`define CXLT_F_PUMP        5
`define CXLT_F_OSC         8:6
`define CXLT_F_DRV         9
`define CXLT_F_MODE        11:10
`define CXLT_F_MODE_HI     11
`define CXLT_OSC_OFF       3'h1

// Status register layout.
`define CXLT_S_LOCK        0
`define CXLT_S_DIR         1
`define CXLT_S_REFL        2

// Interrupt status and mask layout.
`define CXLT_IRQ_W         3
`define CXLT_IRQ_RST       3'h0
`define CXLT_I_LOSE        0
`define CXLT_I_RELOCK      1
`define CXLT_I_REFL        2

// Monitor input bit positions.
`define CXLT_M_LOCK        0
`define CXLT_M_HIGH        1
`define CXLT_M_LOW         2
`define CXLT_M_REFL        3

`endif

// File: cxlt_lock_mon.sv
`timescale 1ns/1ps
`include "cxlt_defs.svh"
module cxlt_lock_mon (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Asynchronous loop detector levels.
  input  wire logic [3:0] loop_mon_raw,
  // Condensed loop state.
  cxlt_mon_if.mon         mon
);
  import cxlt_pkg::*;

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       lock_now;
  logic       lock_q;
  logic       dir_q;
  logic       lose_q;
  logic       relock_q;
  logic       refl_q;
  logic       refl_ev_q;

  // The detector levels come from the analog side, so each bit is synchronised.
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= loop_mon_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // Leaving the fine range or losing the reference counts as unlocked.
  assign lock_now = sync2_q[`CXLT_M_LOCK] & ~sync2_q[`CXLT_M_HIGH]
                  & ~sync2_q[`CXLT_M_LOW] & ~sync2_q[`CXLT_M_REFL];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_q    <= 1'b0;
      lose_q    <= 1'b0;
      relock_q  <= 1'b0;
      refl_q    <= 1'b0;
      refl_ev_q <= 1'b0;
    end else begin
      lock_q    <= lock_now;
      lose_q    <= lock_q & ~lock_now;
      relock_q  <= ~lock_q & lock_now;
      refl_q    <= sync2_q[`CXLT_M_REFL];
      refl_ev_q <= ~refl_q & sync2_q[`CXLT_M_REFL];
    end
  end

  // Direction is caught only at the lock-loss edge and held otherwise.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_q <= 1'b0;
    end else if (lock_q & ~lock_now) begin
      dir_q <= sync2_q[`CXLT_M_HIGH];
    end
  end

  assign mon.lock_ok   = lock_q;
  assign mon.range_dir = dir_q;
  assign mon.ref_lost  = refl_q;
  assign mon.lose_ev   = lose_q;
  assign mon.relock_ev = relock_q;
  assign mon.refl_ev   = refl_ev_q;

endmodule : cxlt_lock_mon

// File: cxlt_loop_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side loop model
// ----------------------------------------
// The analog loop is reduced to its four detector levels. A lost reference
// also drags the oscillator below its fine range as it heads for zero.
module cxlt_loop_model (
  // Clock.
  input  wire logic       clk,
  // Condition from the bench: 0 locked, 1 high, 2 low, 3 no reference.
  input  wire logic [1:0] cond,
  // Detector levels.
  output logic      [3:0] loop_mon_raw
);
  always_ff @(posedge clk) begin
    loop_mon_raw[0] <= (cond == 2'h0);
    loop_mon_raw[1] <= (cond == 2'h1);
    loop_mon_raw[2] <= cond[1];
    loop_mon_raw[3] <= (cond == 2'h3);
  end
endmodule : cxlt_loop_model

// File: cxlt_mon_if.sv
`timescale 1ns/1ps
interface cxlt_mon_if;
  logic lock_ok;
  logic range_dir;
  logic ref_lost;
  logic lose_ev;
  logic relock_ev;
  logic refl_ev;
  modport mon (output lock_ok, range_dir, ref_lost, lose_ev, relock_ev, refl_ev);
  modport ctl (input  lock_ok, range_dir, ref_lost, lose_ev, relock_ev, refl_ev);
endinterface : cxlt_mon_if

// File: cxlt_pin_ctl.sv
`timescale 1ns/1ps
module cxlt_pin_ctl (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Configuration.
  input  wire logic                 drv_sel,
  input  wire cxlt_pkg::cxlt_mode_t mode,
  // Flags to show.
  input  wire logic                 lock_ok,
  input  wire logic                 range_dir,
  // Pin.
  output logic                      pin_o,
  output logic                      pin_oe_n
);
  import cxlt_pkg::*;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      // In PECL style the pin is a current-setting input and must float.
      pin_oe_n <= ~drv_sel;
      unique case (mode)
        CXLT_MODE_LOCK:  pin_o <= lock_ok;
        CXLT_MODE_RANGE: pin_o <= range_dir;
        // Phase and divider monitor sources live outside this block.
        CXLT_MODE_PHASE: pin_o <= 1'b0;
        CXLT_MODE_FBK:   pin_o <= 1'b0;
      endcase
    end
  end

endmodule : cxlt_pin_ctl

// File: cxlt_pkg.sv
package cxlt_pkg;

  typedef enum logic [1:0] {
    CXLT_MODE_LOCK  = 2'h0,
    CXLT_MODE_RANGE = 2'h1,
    CXLT_MODE_PHASE = 2'h2,
    CXLT_MODE_FBK   = 2'h3
  } cxlt_mode_t;

  typedef enum logic {
    CXLT_OUT_PECL = 1'b0,
    CXLT_OUT_CMOS = 1'b1
  } cxlt_style_t;

endpackage : cxlt_pkg

// File: cxlt_top.sv
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cxlt_defs.svh"
//
// Contract
// - Four-bit coarse code sets load capacitance.
// - Fine-tune enable bit turns fine tuning.
// - Status mode 00 selects lock status.
// - Lock mode: pin low while unlocked.
// - Lock mode: readback upper bit shows lock.
// - Status mode 01 selects range direction.
// - Range mode: pin shows latched direction.
// - Range mode: readback upper bit shows direction.
// - Direction latched only at lock loss.
// - Lost reference raises lock error flag.
// - Fine-range exit is lock loss, direction latched.
// - Pump disable bit stops charge pump.
// - Output style selects CMOS or PECL.
// - PECL: pin is current programming input.
// - Pin driven only with driver select set.
//
module cxlt_top (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Avalon-MM slave.
  input  wire logic [`CXLT_ADDR_W-1:0]   avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Loop detector levels from the analog side.
  input  wire logic [3:0]                loop_mon_raw,
  // Oscillator and loop controls.
  output logic      [3:0]                coarse_load_code,
  output logic                           fine_tune_enable,
  output logic                           loop_pump_disable,
  output logic      [2:0]                osc_control_field,
  output logic                           osc_shutdown,
  output cxlt_pkg::cxlt_style_t          output_style,
  // Status or current pin.
  output logic                           status_or_current_pin_o,
  output logic                           status_or_current_pin_oe_n,
  // Interrupt.
  output logic                           irq
);
  import cxlt_pkg::*;

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------

  logic                    ack_q;
  logic                    req;
  logic                    wr_en;
  logic                    rd_sel;
  logic [`CXLT_CTRL_W-1:0] ctrl_q;
  logic [`CXLT_IRQ_W-1:0]  irq_stat_q;
  logic [`CXLT_IRQ_W-1:0]  irq_mask_q;
  logic [`CXLT_IRQ_W-1:0]  irq_set;
  logic [`CXLT_CTRL_W-1:0] ctrl_rd;
  logic [31:0]             rd_d;
  cxlt_mode_t              mode;

  cxlt_mon_if mon_if ();

  // Every access takes one wait cycle; read data is registered in it.
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en           = avs_write & ack_q;
  assign rd_sel          = avs_read & ~ack_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `CXLT_CTRL_RST;
    end else if (wr_en && avs_address == `CXLT_OFF_CTRL) begin
      ctrl_q <= avs_writedata[`CXLT_CTRL_W-1:0];
    end
  end

  // Mode comes from the stored bits, so flag changes never move it.
  assign mode = cxlt_mode_t'(ctrl_q[`CXLT_F_MODE]);

  assign coarse_load_code  = ctrl_q[`CXLT_F_CODE];
  assign fine_tune_enable  = ctrl_q[`CXLT_F_FINE];
  assign loop_pump_disable = ctrl_q[`CXLT_F_PUMP];
  assign osc_control_field = ctrl_q[`CXLT_F_OSC];
  // Writing the shutdown code is how software stops an unfitted crystal.
  assign osc_shutdown      = (ctrl_q[`CXLT_F_OSC] == `CXLT_OSC_OFF);
  assign output_style      = cxlt_style_t'(ctrl_q[`CXLT_F_DRV]);

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------

  always_comb begin
    ctrl_rd = ctrl_q;
    unique case (mode)
      CXLT_MODE_LOCK:  ctrl_rd[`CXLT_F_MODE_HI] = mon_if.lock_ok;
      CXLT_MODE_RANGE: ctrl_rd[`CXLT_F_MODE_HI] = mon_if.range_dir;
      CXLT_MODE_PHASE: ctrl_rd[`CXLT_F_MODE_HI] = ctrl_q[`CXLT_F_MODE_HI];
      CXLT_MODE_FBK:   ctrl_rd[`CXLT_F_MODE_HI] = ctrl_q[`CXLT_F_MODE_HI];
    endcase
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (avs_address)
      `CXLT_OFF_CTRL: begin
        rd_d[`CXLT_CTRL_W-1:0] = ctrl_rd;
      end
      `CXLT_OFF_STATUS: begin
        rd_d[`CXLT_S_LOCK] = mon_if.lock_ok;
        rd_d[`CXLT_S_DIR]  = mon_if.range_dir;
        rd_d[`CXLT_S_REFL] = mon_if.ref_lost;
      end
      `CXLT_OFF_IRQ_STAT: begin
        rd_d[`CXLT_IRQ_W-1:0] = irq_stat_q;
      end
      `CXLT_OFF_IRQ_MASK: begin
        rd_d[`CXLT_IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_sel) begin
      avs_readdata <= rd_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------

  assign irq_set[`CXLT_I_LOSE]   = mon_if.lose_ev;
  assign irq_set[`CXLT_I_RELOCK] = mon_if.relock_ev;
  assign irq_set[`CXLT_I_REFL]   = mon_if.refl_ev;

  // A new event in the clearing cycle wins, so no event is lost.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= `CXLT_IRQ_RST;
    end else if (wr_en && avs_address == `CXLT_OFF_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata[`CXLT_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_q <= `CXLT_IRQ_RST;
    end else if (wr_en && avs_address == `CXLT_OFF_IRQ_MASK) begin
      irq_mask_q <= avs_writedata[`CXLT_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Loop monitor and pin
  // ---------------------------------------------------------------

  cxlt_lock_mon u_mon (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .loop_mon_raw (loop_mon_raw),
    .mon          (mon_if.mon)
  );

  cxlt_pin_ctl u_pin (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .drv_sel   (ctrl_q[`CXLT_F_DRV]),
    .mode      (mode),
    .lock_ok   (mon_if.lock_ok),
    .range_dir (mon_if.range_dir),
    .pin_o     (status_or_current_pin_o),
    .pin_oe_n  (status_or_current_pin_oe_n)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic ctrl_wr;
  assign ctrl_wr = wr_en && avs_address == `CXLT_OFF_CTRL;

  a_coarse_code_write: assert property (
    ctrl_wr |=> coarse_load_code == $past(avs_writedata[3:0]))
    else $error("Coarse code does not follow the control write.");

  a_fine_tune_write: assert property (
    ctrl_wr |=> fine_tune_enable == $past(avs_writedata[4]))
    else $error("Fine-tune enable does not follow the control write.");

  a_pump_dis_write: assert property (
    ctrl_wr |=> loop_pump_disable == $past(avs_writedata[5]))
    else $error("Pump disable does not follow the control write.");

  a_lock_pin_low: assert property (
    (mode == CXLT_MODE_LOCK && ctrl_q[`CXLT_F_DRV] && !mon_if.lock_ok)
    |=> !status_or_current_pin_o && !status_or_current_pin_oe_n)
    else $error("Status pin not driven low while unlocked.");

  a_lock_readback: assert property (
    (rd_sel && avs_address == `CXLT_OFF_CTRL && mode == CXLT_MODE_LOCK)
    |=> avs_readdata[`CXLT_F_MODE_HI] == $past(mon_if.lock_ok))
    else $error("Lock readback does not show the lock flag.");

  a_range_pin_dir: assert property (
    (mode == CXLT_MODE_RANGE && ctrl_q[`CXLT_F_DRV])
    |=> status_or_current_pin_o == $past(mon_if.range_dir))
    else $error("Status pin does not show the range direction.");

  a_range_readback: assert property (
    (rd_sel && avs_address == `CXLT_OFF_CTRL && mode == CXLT_MODE_RANGE)
    |=> avs_readdata[`CXLT_F_MODE_HI] == $past(mon_if.range_dir))
    else $error("Range readback does not show the direction.");

  a_dir_hold_only: assert property (
    $changed(mon_if.range_dir) |-> mon_if.lose_ev)
    else $error("Direction flag changed without a lock loss.");

  a_range_exit_lose: assert property (
    (mon_if.lock_ok && u_mon.sync2_q[`CXLT_M_HIGH])
    |=> mon_if.lose_ev && mon_if.range_dir && !mon_if.lock_ok)
    else $error("High range exit not taken as lock loss.");

  a_ref_lost_err: assert property (
    $rose(mon_if.ref_lost) |-> ##[0:1] irq_stat_q[`CXLT_I_REFL] && !mon_if.lock_ok)
    else $error("Reference loss did not raise the error flag.");

  a_pin_no_drive: assert property (
    !ctrl_q[`CXLT_F_DRV] |=> status_or_current_pin_oe_n)
    else $error("Status pin driven without driver select.");

  a_mode_stored: assert property (
    !ctrl_wr |=> $stable(mode))
    else $error("Mode changed without a control write.");

  a_set_beats_clr: assert property (
    irq_set[`CXLT_I_LOSE] |=> irq_stat_q[`CXLT_I_LOSE])
    else $error("Lock loss event lost in interrupt status.");

  c_lock_lost: cover property (
    mon_if.lock_ok ##1 mon_if.lose_ev);

  c_range_read: cover property (
    rd_sel && mode == CXLT_MODE_RANGE ##1 ack_q);

  c_irq_clear: cover property (
    irq ##[1:20] !irq);

  // ---------------------------------------------------------------
  // Bus, register, interrupt, loop monitor and pin assertions
  // ---------------------------------------------------------------

  // The slave always answers in the second cycle, whatever the address.
  a_wait_once: assert property (
    avs_waitrequest |=> !avs_waitrequest)
    else $error("Request waited more than one cycle.");

  a_ctrl_hold: assert property (
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("Control register changed without a write.");

  a_style_write: assert property (
    ctrl_wr |=> output_style == $past(avs_writedata[`CXLT_F_DRV]))
    else $error("Output style does not follow the control write.");

  a_osc_off_write: assert property (
    (ctrl_wr && avs_writedata[`CXLT_F_OSC] == `CXLT_OSC_OFF) |=> osc_shutdown)
    else $error("Oscillator not shut down by the off code.");

  a_status_read: assert property (
    (rd_sel && avs_address == `CXLT_OFF_STATUS)
    |=> avs_readdata == {29'h0, $past(mon_if.ref_lost), $past(mon_if.range_dir),
                         $past(mon_if.lock_ok)})
    else $error("Status readback does not match the loop flags.");

  a_unmapped_zero: assert property (
    (rd_sel && avs_address[1:0] != 2'h0) |=> avs_readdata == 32'h0000_0000)
    else $error("Unmapped read did not return zero.");

  a_mask_write: assert property (
    (wr_en && avs_address == `CXLT_OFF_IRQ_MASK)
    |=> irq_mask_q == $past(avs_writedata[`CXLT_IRQ_W-1:0]))
    else $error("Interrupt mask does not follow its write.");

  a_irq_clear: assert property (
    (wr_en && avs_address == `CXLT_OFF_IRQ_STAT && irq_set == 3'h0)
    |=> irq_stat_q == ($past(irq_stat_q) & ~$past(avs_writedata[`CXLT_IRQ_W-1:0])))
    else $error("Interrupt status not cleared by writing one.");

  a_irq_sticky: assert property (
    (irq_stat_q[`CXLT_I_LOSE]
      && !(wr_en && avs_address == `CXLT_OFF_IRQ_STAT && avs_writedata[`CXLT_I_LOSE]))
    |=> irq_stat_q[`CXLT_I_LOSE])
    else $error("Lock loss status dropped without a clear.");

  a_range_low_dir: assert property (
    (mon_if.lock_ok && u_mon.sync2_q[`CXLT_M_LOW] && !u_mon.sync2_q[`CXLT_M_HIGH])
    |=> mon_if.lose_ev && !mon_if.range_dir && !mon_if.lock_ok)
    else $error("Low range exit not taken as lock loss.");

  a_refl_unlock: assert property (
    mon_if.ref_lost |-> !mon_if.lock_ok)
    else $error("Lock shown while the reference is lost.");

  a_pin_driven: assert property (
    ctrl_q[`CXLT_F_DRV] |=> !status_or_current_pin_oe_n)
    else $error("Status pin released with driver select set.");

  a_spare_mode_pin: assert property (
    (mode == CXLT_MODE_PHASE || mode == CXLT_MODE_FBK) |=> !status_or_current_pin_o)
    else $error("Status pin not low in a mode served outside this block.");

  c_ref_lost: cover property (
    $rose(mon_if.ref_lost));

  c_pin_release: cover property (
    !ctrl_q[`CXLT_F_DRV] ##1 status_or_current_pin_oe_n);

endmodule : cxlt_top

// File: cxlt_top_test.sv
`timescale 1ns/1ps
`include "cxlt_defs.svh"
module cxlt_top_test;
  import cxlt_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  cond;
  logic [3:0]  loop_mon_raw;
  logic [3:0]  coarse_load_code;
  logic        fine_tune_enable;
  logic        loop_pump_disable;
  logic [2:0]  osc_control_field;
  logic        osc_shutdown;
  cxlt_style_t output_style;
  logic        pin_o;
  logic        pin_oe_n;
  logic        irq;
  logic [11:0] v;
  logic [31:0] exp_q[$];
  int          fail_count;
  int          n_checks;

  always #5 clk = ~clk;

  cxlt_top i_cxlt_top (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .loop_mon_raw(loop_mon_raw),
    .coarse_load_code(coarse_load_code), .fine_tune_enable(fine_tune_enable),
    .loop_pump_disable(loop_pump_disable), .osc_control_field(osc_control_field),
    .osc_shutdown(osc_shutdown), .output_style(output_style),
    .status_or_current_pin_o(pin_o), .status_or_current_pin_oe_n(pin_oe_n), .irq(irq)
  );

  cxlt_loop_model i_cxlt_loop_model (.clk(clk), .cond(cond), .loop_mon_raw(loop_mon_raw));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
    n_checks++;
    if (got !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, e, got);
    end
  endtask : chk

  // Only the watchdog ends a wait; one idle edge keeps two calls from colliding.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Model flop, two sync stages, lock flop and pin flop take five edges; one spare.
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic pin(input logic [1:0] e);
    chk("pin o and oe_n", {30'h0, e}, {30'h0, pin_o, pin_oe_n});
  endtask : pin

  task automatic finish_test();
    if (exp_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // The read answer is taken at the edge where waitrequest is seen low.
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("mismatch readdata expected none seen %h", avs_readdata);
      end else begin
        chk("readdata", exp_q.pop_front(), avs_readdata);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    cond = 2'h0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(93));
    repeat (10) @(posedge clk);
    chk("irq in reset", 32'h0, {31'h0, irq});
    pin(2'b01);
    sys_rst <= 1'b0;
    settle();
    rd(`CXLT_OFF_CTRL, 32'h800);
    for (int i = 0; i < 8; i++) begin
      v = 12'($urandom()) & 12'h3FF;
      if (i == 0) v[8:6] = `CXLT_OSC_OFF;
      bus(1'b1, `CXLT_OFF_CTRL, {20'h0, v});
      @(posedge clk);
      chk("ctrl outputs", {22'h0, v[9:0]},
          {22'h0, output_style, osc_control_field, loop_pump_disable, fine_tune_enable,
           coarse_load_code});
      chk("osc_shutdown", {31'h0, v[8:6] == 3'h1}, {31'h0, osc_shutdown});
      rd(`CXLT_OFF_CTRL, {20'h0, v | 12'h800});
    end
    bus(1'b1, `CXLT_OFF_CTRL, 32'h200);
    settle();
    pin(2'b10);
    cond <= 2'h1;
    settle();
    pin(2'b00);
    rd(`CXLT_OFF_CTRL, 32'h200);
    rd(`CXLT_OFF_STATUS, 32'h2);
    // Leaving reset with the loop locked is a relock, so bit one is already set.
    rd(`CXLT_OFF_IRQ_STAT, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, `CXLT_OFF_IRQ_MASK, 32'h1);
    settle();
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, `CXLT_OFF_IRQ_STAT, 32'h1);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, `CXLT_OFF_CTRL, 32'h600);
    settle();
    pin(2'b10);
    rd(`CXLT_OFF_CTRL, 32'hE00);
    cond <= 2'h0;
    settle();
    pin(2'b10);
    rd(`CXLT_OFF_STATUS, 32'h3);
    rd(`CXLT_OFF_IRQ_STAT, 32'h2);
    cond <= 2'h2;
    settle();
    pin(2'b00);
    rd(`CXLT_OFF_CTRL, 32'h600);
    cond <= 2'h1;
    settle();
    pin(2'b00);
    cond <= 2'h3;
    settle();
    rd(`CXLT_OFF_STATUS, 32'h4);
    rd(`CXLT_OFF_IRQ_STAT, 32'h7);
    bus(1'b1, `CXLT_OFF_IRQ_MASK, 32'h4);
    settle();
    chk("irq on lost source", 32'h1, {31'h0, irq});
    bus(1'b1, `CXLT_OFF_IRQ_STAT, 32'h7);
    settle();
    rd(`CXLT_OFF_IRQ_STAT, 32'h0);
    chk("irq after clear", 32'h0, {31'h0, irq});
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b1, `CXLT_OFF_STATUS, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    rd(`CXLT_OFF_STATUS, 32'h4);
    rd(`CXLT_OFF_CTRL, 32'h600);
    bus(1'b1, `CXLT_OFF_CTRL, 32'h400);
    settle();
    pin(2'b01);
    chk("style", 32'h0, {31'h0, output_style});
    bus(1'b1, `CXLT_OFF_CTRL, 32'hA00);
    settle();
    pin(2'b00);
    rd(`CXLT_OFF_CTRL, 32'hA00);
    // A second reset in mid-run drops the configuration and releases the pin.
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    pin(2'b01);
    chk("irq in second reset", 32'h0, {31'h0, irq});
    sys_rst <= 1'b0;
    settle();
    rd(`CXLT_OFF_CTRL, 32'h000);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : cxlt_top_test
